// ---- hw/tdp_defines.vh ----
// register map, field codes and timing constants of the delayed pulse timer
`ifndef TDP_DEFINES_VH
`define TDP_DEFINES_VH

// ======================================================================
// register byte offsets
`define TDP_OFS_CTRL       4'h0
`define TDP_OFS_DELAY      4'h4
`define TDP_OFS_LENGTH     4'h8
`define TDP_OFS_COUNT      4'hC
`define TDP_OFS_RUN        5'h10
`define TDP_OFS_CMD        5'h14

// ======================================================================
// control register fields
`define TDP_CTRL_SRC_LSB   0
`define TDP_CTRL_SRC_W     3
`define TDP_CTRL_COND_LSB  4
`define TDP_CTRL_COND_W    2
`define TDP_CTRL_LINE_BIT  8

// trigger_source_select codes
`define TDP_SRC_OFF        3'h0
`define TDP_SRC_EXPOSURE   3'h1
`define TDP_SRC_READOUT    3'h2
`define TDP_SRC_LINE       3'h3
`define TDP_SRC_STROBE     3'h4

// trigger_condition codes
`define TDP_COND_EDGE_UP   2'h0
`define TDP_COND_EDGE_DOWN 2'h1
`define TDP_COND_GATE_HIGH 2'h2
`define TDP_COND_GATE_LOW  2'h3

// run_state codes
`define TDP_RUN_IDLE       2'h0
`define TDP_RUN_WAITING    2'h1
`define TDP_RUN_RUNNING    2'h2

// ======================================================================
// reset values and timing
`define TDP_RST_DELAY      32'h0000_0000
`define TDP_RST_LENGTH     32'h0000_0001
`define TDP_MAX_US         32'h0393_8700
`define TDP_CLK_MHZ        25
`define TDP_US_NS          1000
`define TDP_CLK_NS         40

`endif

// ---- hw/tdp_us_tick.v ----
// one-microsecond enable pulse derived from the system clock
`timescale 1ns/100ps
`include "tdp_defines.vh"
module tdp_us_tick
#(
  parameter DIV = (`TDP_US_NS / `TDP_CLK_NS)
)
(
  input  wire aclk,
  input  wire aresetn,
  input  wire clear,
  output reg  tick_ff
);
  reg  [7:0] cnt_ff;

  // clear realigns the microsecond grid so a restart times from zero
  always @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff == DIV[7:0] - 8'h01)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff  <= cnt_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end
endmodule

// ---- hw/tdp_timer.v ----
// triggered delayed pulse timer with AXI4-Lite register access
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tdp_defines.vh"

// Summary of operation
// - timer output drives the line output when line_output_select picks the timer source.
// - edge activation holds the pulse high for pulse_length microseconds, 1 to 60,000,000.
// - start_delay of 0 to 60,000,000 microseconds passes before the active phase.
// - restart_command clears progress and starts timer operation afresh.
// - present_count is readable by software at any time.
// - run_state reports idle, waiting or running.
// - trigger source is off, exposure, readout, external line or strobe.
// - edge_up treats each low-to-high transition as a trigger.
// - edge_down treats each high-to-low transition as a trigger.
// - gate_when_high keeps output valid while the source stays high.
// - gate_when_low keeps output valid while the source stays low.
// - the source arriving starts the timer and the start delay counts first.
// - after the delay in high gating, output stays high while source is high.
// - exposure window is high from exposure start to exposure end.
// - strobe rises at bottom row exposure start, falls at top row exposure end.
module tdp_timer
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        exposure_window,
  input  wire        readout_window,
  input  wire        strobe_window,
  input  wire        external_input_line,
  output reg         timer_output_ff,
  output reg         line_output_ff,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;
  localparam [1:0] RESP_OK  = 2'b00;
  localparam [1:0] RESP_ERR = 2'b10;

  // ====================================================================
  // register storage
  reg  [2:0]  src_sel_ff;
  reg  [1:0]  cond_ff;
  reg         line_sel_ff;
  reg  [31:0] start_delay_ff;
  reg  [31:0] pulse_length_ff;
  reg         restart_ff;
  reg  [4:0]  aw_addr_ff;
  reg         aw_have_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_have_ff;

  // ====================================================================
  // source selection and detection
  reg         line_meta_ff;
  reg         line_sync_ff;
  reg         src_ff;
  reg         src_prev_ff;
  reg         src_now;
  wire        us_tick;

  // two flops before anything looks at the pin
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_meta_ff <= 1'b0;
      line_sync_ff <= 1'b0;
    end
    else
    begin
      line_meta_ff <= external_input_line;
      line_sync_ff <= line_meta_ff;
    end
  end

  // exposure, readout and strobe windows come from logic on this clock
  always @*
  begin
    case (src_sel_ff)
      `TDP_SRC_EXPOSURE: src_now = exposure_window;
      `TDP_SRC_READOUT:  src_now = readout_window;
      `TDP_SRC_LINE:     src_now = line_sync_ff;
      `TDP_SRC_STROBE:   src_now = strobe_window;
      default:           src_now = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_ff      <= 1'b0;
      src_prev_ff <= 1'b0;
    end
    else
    begin
      src_ff      <= src_now;
      src_prev_ff <= src_ff;
    end
  end

  wire rise_evt  = src_ff & ~src_prev_ff;
  wire fall_evt  = ~src_ff & src_prev_ff;
  wire gate_lvl  = (cond_ff == `TDP_COND_GATE_LOW) ? ~src_ff : src_ff;
  wire is_gate   = cond_ff[1];
  wire edge_evt  = (cond_ff == `TDP_COND_EDGE_DOWN) ? fall_evt : rise_evt;
  wire src_off   = (src_sel_ff == `TDP_SRC_OFF);

  // ====================================================================
  // microsecond timebase
  tdp_us_tick u_tick
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (restart_ff),
    .tick_ff (us_tick)
  );

  // ====================================================================
  // timer state machine
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [31:0] count_ff;
  reg  [31:0] nxt_count;
  reg         in_delay_ff;
  reg         nxt_in_delay;
  reg         nxt_out;

  // delay phase counts up to start_delay, then active phase up to pulse_length under edge conditions
  always @*
  begin
    nxt_state    = state_ff;
    nxt_count    = count_ff;
    nxt_in_delay = in_delay_ff;
    nxt_out      = timer_output_ff;
    if (restart_ff || src_off)
    begin
      nxt_state    = src_off ? ST_IDLE : ST_WAIT;
      nxt_count    = 32'h0000_0000;
      nxt_in_delay = 1'b1;
      nxt_out      = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          nxt_state = ST_WAIT;
        end
        ST_WAIT:
        begin
          if (is_gate ? gate_lvl : edge_evt)
          begin
            nxt_state    = ST_RUN;
            nxt_count    = 32'h0000_0000;
            nxt_in_delay = 1'b1;
          end
        end
        ST_RUN:
        begin
          if (in_delay_ff)
          begin
            if (is_gate && !gate_lvl)
            begin
              nxt_state = ST_WAIT;
            end
            else if (count_ff >= start_delay_ff)
            begin
              nxt_in_delay = 1'b0;
              nxt_count    = 32'h0000_0000;
              nxt_out      = 1'b1;
            end
            else if (us_tick)
            begin
              nxt_count = count_ff + 32'h0000_0001;
            end
          end
          else if (is_gate)
          begin
            if (!gate_lvl)
            begin
              nxt_out   = 1'b0;
              nxt_state = ST_WAIT;
            end
            else if (us_tick)
            begin
              nxt_count = count_ff + 32'h0000_0001;
            end
          end
          else if (us_tick)
          begin
            if (count_ff + 32'h0000_0001 >= pulse_length_ff)
            begin
              nxt_out   = 1'b0;
              nxt_state = ST_WAIT;
            end
            nxt_count = count_ff + 32'h0000_0001;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff        <= ST_IDLE;
      count_ff        <= 32'h0000_0000;
      in_delay_ff     <= 1'b1;
      timer_output_ff <= 1'b0;
      line_output_ff  <= 1'b0;
    end
    else
    begin
      state_ff        <= nxt_state;
      count_ff        <= nxt_count;
      in_delay_ff     <= nxt_in_delay;
      timer_output_ff <= nxt_out;
      line_output_ff  <= line_sel_ff & nxt_out;
    end
  end

  reg  [1:0] run_code;
  always @*
  begin
    case (state_ff)
      ST_WAIT: run_code = `TDP_RUN_WAITING;
      ST_RUN:  run_code = `TDP_RUN_RUNNING;
      default: run_code = `TDP_RUN_IDLE;
    endcase
  end

  // ====================================================================
  // AXI4-Lite write path
  wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  wire        do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;

  // values above the documented range are clamped so the timer stays legal
  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lo;
    begin
      if (v > `TDP_MAX_US)
        clamp = `TDP_MAX_US;
      else if (v < lo)
        clamp = lo;
      else
        clamp = v;
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff      <= 1'b0;
      w_have_ff       <= 1'b0;
      aw_addr_ff      <= 5'h00;
      w_data_ff       <= 32'h0000_0000;
      w_strb_ff       <= 4'h0;
      s_axi_awready   <= 1'b1;
      s_axi_wready    <= 1'b1;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= RESP_OK;
      src_sel_ff      <= `TDP_SRC_OFF;
      cond_ff         <= `TDP_COND_EDGE_UP;
      line_sel_ff     <= 1'b0;
      start_delay_ff  <= `TDP_RST_DELAY;
      pulse_length_ff <= `TDP_RST_LENGTH;
      restart_ff      <= 1'b0;
    end
    else
    begin
      restart_ff <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_ff    <= s_axi_awaddr;
        aw_have_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        w_have_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OK;
        case (aw_addr_ff[4:2])
          3'h0:
          begin
            if (w_strb_ff[0])
            begin
              src_sel_ff <= w_data_ff[`TDP_CTRL_SRC_LSB +: `TDP_CTRL_SRC_W];
              cond_ff    <= w_data_ff[`TDP_CTRL_COND_LSB +: `TDP_CTRL_COND_W];
            end
            if (w_strb_ff[1])
              line_sel_ff <= w_data_ff[`TDP_CTRL_LINE_BIT];
          end
          3'h1: start_delay_ff  <= clamp((start_delay_ff & ~wmask) | (w_data_ff & wmask), 32'h0000_0000);
          3'h2: pulse_length_ff <= clamp((pulse_length_ff & ~wmask) | (w_data_ff & wmask), 32'h0000_0001);
          3'h3: ;
          3'h4: ;
          3'h5: restart_ff <= w_strb_ff[0] & w_data_ff[0];
          default: s_axi_bresp <= RESP_ERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_have_ff    <= 1'b0;
        w_have_ff     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ====================================================================
  // AXI4-Lite read path
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      case (s_axi_araddr[4:2])
        3'h0: s_axi_rdata <= {23'h000000, line_sel_ff, 2'h0, cond_ff, 1'b0, src_sel_ff};
        3'h1: s_axi_rdata <= start_delay_ff;
        3'h2: s_axi_rdata <= pulse_length_ff;
        3'h3: s_axi_rdata <= count_ff;
        3'h4: s_axi_rdata <= {29'h00000000, in_delay_ff & (state_ff == ST_RUN), run_code};
        3'h5: s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ---- tb/tdp_timer_sva.sv ----
// assertion checker watching the ports of the delayed pulse timer
`timescale 1ns/100ps
module tdp_timer_sva
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        timer_output_ff,
  input wire logic        line_output_ff,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ======================================================================
  // handshake sequences
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ======================================================================
  // properties
  a_line_gated: assert property (line_output_ff |-> timer_output_ff)
    else $error("line output high while timer output low");
  a_b_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
    else $error("write response missing two cycles after address and data");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response kept after handshake");
  a_r_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing one cycle after address");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_aw_shut: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while response pending");
  a_ar_shut: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while read data pending");
  a_unmapped_err: assert property (s_rd_taken ##0 (s_axi_araddr >= 5'h18) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not answered with error and zero");
endmodule

bind tdp_timer tdp_timer_sva u_sva (.*);

// ---- tb/tdp_flash_model.sv ----
// flash unit model counting the pulses that arrive on the line output
`timescale 1ns/100ps
module tdp_flash_model
(
  input wire logic aclk,
  input wire logic fire,
  output int       pulse_count
);
  logic fire_d;
  initial
  begin
    pulse_count = 0;
    fire_d = 1'b0;
  end
  // a flash fires once per rising edge of its trigger line
  always @(posedge aclk)
  begin
    if (fire && !fire_d)
      pulse_count <= pulse_count + 1;
    fire_d <= fire;
  end
endmodule

// ---- tb/tb_tdp_timer.sv ----
// self-checking testbench of the delayed pulse timer
`timescale 1ns/100ps
`include "tdp_defines.vh"
module tb_tdp_timer;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  src_lv = 4'h0;
  logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         timer_output_ff, line_output_ff;
  wire         exposure_window = src_lv[0];
  wire         readout_window = src_lv[1];
  wire         external_input_line = src_lv[2];
  wire         strobe_window = src_lv[3];
  int          n_errors = 0, check_count = 0, pulses, exp_pulses = 0, dly, len, t;
  int          rst_q[$] = '{0, 0, 1, 0, 0};
  logic [1:0]  r;
  logic [31:0] rd;

  always #20 aclk = ~aclk;
  tdp_timer DUT (.*);
  tdp_flash_model u_flash (.aclk(aclk), .fire(line_output_ff), .pulse_count(pulses));

  // ======================================================================
  // compare and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic signed [31:0] g);
    check_count++;
    if (^g === 1'bx || g < lo || g > hi)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_out(input logic lv);
    t = 0;
    do
    begin
      @(posedge aclk);
      t++;
    end while (timer_output_ff !== lv);
  endtask

  // ======================================================================
  // one trigger of source s under condition c, model times in whole microseconds
  task automatic run_case(input int s, input int c);
    logic act;
    logic ln;
    act = (c == 0 || c == 2);
    ln = (s != 4);
    dly = $urandom % 4;
    len = 1 + $urandom % 4;
    // park the timer first so the idle levels below cannot fire the previous setup
    wr(`TDP_OFS_CTRL, 32'h0);
    src_lv <= act ? 4'h0 : 4'hF;
    wr(`TDP_OFS_DELAY, dly);
    wr(`TDP_OFS_LENGTH, len);
    wr(`TDP_OFS_CTRL, {23'h0, ln, 2'h0, c[1:0], 1'b0, s[2:0]});
    rdr(`TDP_OFS_RUN);
    chk("run state armed", {30'h0, `TDP_RUN_WAITING}, rd);
    src_lv[s-1] <= act;
    wait_out(1'b1);
    chk_rng("rise delay", (dly - 1) * 25, dly * 25 + 30, t);
    chk("line output", {31'h0, ln}, {31'h0, line_output_ff});
    if (ln) exp_pulses++;
    if (c < 2)
    begin
      src_lv[s-1] <= !act;
      wait_out(1'b0);
      chk_rng("pulse width", len * 25 - 26, len * 25 + 30, t);
      rdr(`TDP_OFS_RUN);
      chk("run state after pulse", {30'h0, `TDP_RUN_WAITING}, rd);
    end
    else
    begin
      t = 0;
      repeat (200)
      begin
        @(posedge aclk);
        if (!timer_output_ff) t++;
      end
      chk("gate held", 0, t);
      src_lv[s-1] <= !act;
      wait_out(1'b0);
      chk_rng("gate release", (s == 3) ? 4 : 2, (s == 3) ? 5 : 3, t);
    end
  endtask

  // ======================================================================
  // main sequence
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(42206));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_q[i])
    begin
      rdr(5'(i * 4));
      chk("reset value", rst_q[i], rd);
    end
    rdr(5'h18);
    chk("unmapped read", 32'h2, {30'h0, r});
    wr(5'h1C, 32'h5);
    chk("unmapped write", 32'h2, {30'h0, r});
    wr(`TDP_OFS_DELAY, 32'h0393_8701);
    rdr(`TDP_OFS_DELAY);
    chk("delay ceiling", `TDP_MAX_US, rd);
    wr(`TDP_OFS_LENGTH, 32'h0);
    rdr(`TDP_OFS_LENGTH);
    chk("length floor", 32'h1, rd);
    $display("test registers done");
    for (int s = 1; s <= 4; s++)
      for (int c = 0; c < 4; c++)
        run_case(s, c);
    chk("flash pulses", exp_pulses, pulses);
    $display("test sources and conditions done");
    wr(`TDP_OFS_CTRL, 32'h0);
    src_lv <= 4'h0;
    wr(`TDP_OFS_DELAY, 32'd200);
    wr(`TDP_OFS_CTRL, {26'h0, `TDP_COND_EDGE_UP, 1'b0, `TDP_SRC_EXPOSURE});
    src_lv[0] <= 1'b1;
    repeat (2000) @(posedge aclk);
    rdr(`TDP_OFS_COUNT);
    chk_rng("count in delay", 70, 82, rd);
    wr(`TDP_OFS_CMD, 32'h1);
    rdr(`TDP_OFS_COUNT);
    chk_rng("count after restart", 0, 1, rd);
    rdr(`TDP_OFS_RUN);
    chk("run after restart", {30'h0, `TDP_RUN_WAITING}, rd);
    t = 0;
    repeat (6000)
    begin
      @(posedge aclk);
      if (timer_output_ff) t++;
    end
    chk("no output after restart", 0, t);
    wr(`TDP_OFS_CTRL, 32'h0);
    rdr(`TDP_OFS_RUN);
    chk("run with source off", {30'h0, `TDP_RUN_IDLE}, rd);
    $display("test restart and off done");
    end_sim();
  end
endmodule
